// [shared/hbs_map.vh]
// register map, field layout and timing constants of the hoist brake sequencer
`ifndef HBS_MAP_VH
`define HBS_MAP_VH
// register byte offsets
`define HBS_OFF_CTRL 12'h000
`define HBS_OFF_ENG_DLY 12'h004
`define HBS_OFF_ENG_TIME 12'h008
`define HBS_OFF_RESTART 12'h00c
`define HBS_OFF_RAMP 12'h010
`define HBS_OFF_JUMP 12'h014
`define HBS_OFF_REL_TIME 12'h018
`define HBS_OFF_STATUS 12'h01c
`define HBS_OFF_IRQ_STAT 12'h020
`define HBS_OFF_IRQ_MASK 12'h024
`define HBS_OFF_JUMP_OUT 12'h028
// control fields
`define HBS_CTL_ASSIGNED 0
`define HBS_CTL_REV_ENG 1
`define HBS_CTL_REPEAT 2
`define HBS_CTL_STEADY 3
`define HBS_CTL_CSEQ 4
`define HBS_CTL_MISSRESP 5
`define HBS_CTL_CLOSED 6
`define HBS_CTL_CONTACT 7
`define HBS_CTL_HOIST 8
`define HBS_CTL_W 9
// jump frequency field: bit 15 = automatic, low 8 bits = 0.1 Hz units
`define HBS_JUMP_AUTO 15
`define HBS_JUMP_MAX 8'h64
`define HBS_JUMP_RESET 16'h8000
// times in milliseconds
`define HBS_DLY_MAX 16'h1388
`define HBS_RESTART_MAX 16'h3a98
`define HBS_ENG_TIME_RESET 16'h01f4
`define HBS_REL_TIME_RESET 16'h01f4
// one millisecond at 40 MHz
`define HBS_CLK_KHZ 40000
`define HBS_TICK_CYC 16'h9c40
// interrupt bits
`define HBS_IRQ_FAULT 0
`define HBS_IRQ_WARN 1
`define HBS_IRQ_W 2
`endif

// [rtl/hbs_sequencer.v]
// hoist brake sequencer with apb register file
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "hbs_map.vh"
module hbs_sequencer (
  input wire mclk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire run_cmd,
  input wire reversal_req,
  input wire zero_speed,
  input wire brake_contact,
  input wire fault_reset,
  input wire [7:0] rated_slip,
  output reg brake_relay,
  output reg ref_enable,
  output reg hold_zero,
  output reg [15:0] torque_level,
  output reg jump_active,
  output reg brake_fault,
  output reg brake_warn,
  output reg irq
);
  // states
  localparam ST_ENGAGED = 3'd0;
  localparam ST_RELEASE = 3'd1;
  localparam ST_RUN = 3'd2;
  localparam ST_ENG_DLY = 3'd3;
  localparam ST_ENGAGE = 3'd4;
  localparam ST_DWELL = 3'd5;
  localparam ST_FAULT = 3'd6;
  localparam [15:0] RAMP_FULL = 16'hffff;

  reg [`HBS_CTL_W-1:0] ctrl_q;
  reg [15:0] eng_dly_q, eng_time_q, restart_q, ramp_q, jump_q, rel_time_q;
  reg [`HBS_IRQ_W-1:0] irq_stat_q, irq_mask_q;
  reg [2:0] state_q;
  reg [15:0] tick_cnt_q, timer_q, ramp_cnt_q;
  reg tick_q;
  reg run_s1_q, run_s2_q, rev_s1_q, rev_s2_q, zs_s1_q, zs_s2_q, bc_s1_q, bc_s2_q, fr_s1_q, fr_s2_q;
  reg bc_prev_q, ramp_up_q, ramp_go_q, engage_from_rev_q;
  reg fault_ev, warn_ev;
  reg [15:0] jump_eff;

  wire assigned = ctrl_q[`HBS_CTL_ASSIGNED];
  wire contact_used = ctrl_q[`HBS_CTL_CONTACT];
  wire cseq = ctrl_q[`HBS_CTL_CSEQ] & contact_used;
  wire bc_rise = bc_s2_q & ~bc_prev_q;
  wire bc_fall = ~bc_s2_q & bc_prev_q;
  wire wr = psel & penable & pwrite;
  wire rd_known = (paddr <= `HBS_OFF_JUMP_OUT) && (paddr[1:0] == 2'b00);

  // two-stage synchronisers for every single-bit pin input; rated_slip is used unsynchronised
  always @(posedge mclk) begin
    if (!nrst) begin
      {run_s1_q, run_s2_q, rev_s1_q, rev_s2_q, zs_s1_q} <= 5'h00;
      {zs_s2_q, bc_s1_q, bc_s2_q, fr_s1_q, fr_s2_q, bc_prev_q} <= 6'h00;
    end else begin
      run_s1_q <= run_cmd;
      run_s2_q <= run_s1_q;
      rev_s1_q <= reversal_req;
      rev_s2_q <= rev_s1_q;
      zs_s1_q <= zero_speed;
      zs_s2_q <= zs_s1_q;
      bc_s1_q <= brake_contact;
      bc_s2_q <= bc_s1_q;
      fr_s1_q <= fault_reset;
      fr_s2_q <= fr_s1_q;
      bc_prev_q <= bc_s2_q;
    end
  end

  // millisecond tick; one timebase keeps all delays in the same unit
  always @(posedge mclk) begin
    if (!nrst) begin
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == `HBS_TICK_CYC - 16'h0001) begin
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // jump frequency: automatic takes rated slip, else clamped manual value
  always @* begin
    if (jump_q[`HBS_JUMP_AUTO])
      jump_eff = {8'h00, rated_slip};
    else if (jump_q[7:0] > `HBS_JUMP_MAX)
      jump_eff = {8'h00, `HBS_JUMP_MAX};
    else
      jump_eff = {8'h00, jump_q[7:0]};
  end

  // apb writes; out-of-range times saturate at their maxima
  always @(posedge mclk) begin
    if (!nrst) begin
      ctrl_q <= {`HBS_CTL_W{1'b0}};
      eng_dly_q <= 16'h0000;
      eng_time_q <= `HBS_ENG_TIME_RESET;
      restart_q <= 16'h0000;
      ramp_q <= 16'h0000;
      jump_q <= `HBS_JUMP_RESET;
      rel_time_q <= `HBS_REL_TIME_RESET;
      irq_mask_q <= {`HBS_IRQ_W{1'b0}};
    end else if (wr) begin
      case (paddr)
        `HBS_OFF_CTRL: ctrl_q <= pwdata[`HBS_CTL_W-1:0];
        `HBS_OFF_ENG_DLY: eng_dly_q <= (pwdata[15:0] > `HBS_DLY_MAX) ? `HBS_DLY_MAX : pwdata[15:0];
        `HBS_OFF_ENG_TIME: eng_time_q <= (pwdata[15:0] > `HBS_DLY_MAX) ? `HBS_DLY_MAX : pwdata[15:0];
        `HBS_OFF_RESTART: restart_q <= (pwdata[15:0] > `HBS_RESTART_MAX) ? `HBS_RESTART_MAX : pwdata[15:0];
        `HBS_OFF_RAMP: ramp_q <= (pwdata[15:0] > `HBS_DLY_MAX) ? `HBS_DLY_MAX : pwdata[15:0];
        `HBS_OFF_JUMP: jump_q <= pwdata[15:0];
        `HBS_OFF_REL_TIME: rel_time_q <= (pwdata[15:0] > `HBS_DLY_MAX) ? `HBS_DLY_MAX : pwdata[15:0];
        `HBS_OFF_IRQ_MASK: irq_mask_q <= pwdata[`HBS_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // apb read data and answer; zero wait states, slverr on unmapped
  always @(posedge mclk) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_known;
      case (paddr)
        `HBS_OFF_CTRL: prdata <= {23'h000000, ctrl_q};
        `HBS_OFF_ENG_DLY: prdata <= {16'h0000, eng_dly_q};
        `HBS_OFF_ENG_TIME: prdata <= {16'h0000, eng_time_q};
        `HBS_OFF_RESTART: prdata <= {16'h0000, restart_q};
        `HBS_OFF_RAMP: prdata <= {16'h0000, ramp_q};
        `HBS_OFF_JUMP: prdata <= {16'h0000, jump_q};
        `HBS_OFF_REL_TIME: prdata <= {16'h0000, rel_time_q};
        `HBS_OFF_STATUS: prdata <= {22'h000000, bc_s2_q, jump_active, brake_warn, brake_fault,
          ref_enable, brake_relay, 1'b0, state_q};
        `HBS_OFF_IRQ_STAT: prdata <= {30'h00000000, irq_stat_q};
        `HBS_OFF_IRQ_MASK: prdata <= {30'h00000000, irq_mask_q};
        `HBS_OFF_JUMP_OUT: prdata <= {16'h0000, jump_eff};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
  // pready is asserted during the access cycle itself via the registered setup

  // sticky interrupt status: a new event wins over a write-one clear
  always @(posedge mclk) begin
    if (!nrst) begin
      irq_stat_q <= {`HBS_IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((wr && paddr == `HBS_OFF_IRQ_STAT) ? pwdata[`HBS_IRQ_W-1:0]
        : {`HBS_IRQ_W{1'b0}})) | {warn_ev, fault_ev};
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // contact supervision events
  always @* begin
    fault_ev = 1'b0;
    warn_ev = 1'b0;
    if (assigned && contact_used && state_q != ST_FAULT) begin
      // steady running: contact must stay released (high)
      if (state_q == ST_RUN && !ctrl_q[`HBS_CTL_STEADY] && !bc_s2_q)
        fault_ev = 1'b1;
      // release phase: contact must open before release time ends
      // checked in the very cycle the phase ends; waiting for a tick would never coincide
      if (state_q == ST_RELEASE && timer_q == 16'h0000 && !bc_s2_q && !cseq)
        fault_ev = 1'b1;
      // engage phase end: contact still released
      if (state_q == ST_ENGAGE && ctrl_q[`HBS_CTL_CLOSED] && timer_q == 16'h0000 && bc_s2_q) begin
        if (ctrl_q[`HBS_CTL_MISSRESP])
          warn_ev = 1'b1;
        else
          fault_ev = 1'b1;
      end
    end
  end

  // brake sequence state machine, delays count whole milliseconds
  always @(posedge mclk) begin
    if (!nrst) begin
      state_q <= ST_ENGAGED;
      timer_q <= 16'h0000;
      ramp_up_q <= 1'b0;
      ramp_go_q <= 1'b0;
      engage_from_rev_q <= 1'b0;
      brake_fault <= 1'b0;
      brake_warn <= 1'b0;
      hold_zero <= 1'b1;
    end else if (!assigned) begin
      state_q <= ST_ENGAGED;
      timer_q <= 16'h0000;
      ramp_up_q <= 1'b0;
      ramp_go_q <= 1'b0;
      brake_warn <= 1'b0;
      hold_zero <= 1'b1;
    end else begin
      if (tick_q && timer_q != 16'h0000)
        timer_q <= timer_q - 16'h0001;
      if (warn_ev) begin
        brake_warn <= 1'b1;
        hold_zero <= 1'b1;
      end
      if (fault_ev) begin
        brake_fault <= 1'b1;
        state_q <= ST_FAULT;
        ramp_up_q <= 1'b0;
        ramp_go_q <= 1'b1;
      end else begin
        case (state_q)
          ST_ENGAGED: begin
            hold_zero <= 1'b1;
            if (run_s2_q) begin
              state_q <= ST_RELEASE;
              timer_q <= rel_time_q;
              ramp_up_q <= 1'b1;
              ramp_go_q <= 1'b1;
              brake_warn <= 1'b0;
            end
          end
          ST_RELEASE: begin
            if (cseq ? bc_rise : (timer_q == 16'h0000)) begin
              state_q <= ST_RUN;
              hold_zero <= 1'b0;
            end
          end
          ST_RUN: begin
            // reversal through zero engages only when selected
            if (!run_s2_q || (rev_s2_q && zs_s2_q && ctrl_q[`HBS_CTL_REV_ENG])) begin
              state_q <= ST_ENG_DLY;
              timer_q <= eng_dly_q;
              engage_from_rev_q <= run_s2_q;
              hold_zero <= 1'b1;
            end
          end
          ST_ENG_DLY: begin
            if (timer_q == 16'h0000) begin
              state_q <= ST_ENGAGE;
              timer_q <= eng_time_q;
              ramp_up_q <= 1'b0;
              ramp_go_q <= ~cseq;
            end
          end
          ST_ENGAGE: begin
            if (cseq && bc_fall)
              ramp_go_q <= 1'b1;
            if (run_s2_q && !engage_from_rev_q && ctrl_q[`HBS_CTL_REPEAT]) begin
              state_q <= ST_RELEASE;
              timer_q <= rel_time_q;
              ramp_up_q <= 1'b1;
              ramp_go_q <= 1'b1;
            end else if (timer_q == 16'h0000) begin
              state_q <= ST_DWELL;
              timer_q <= restart_q;
              engage_from_rev_q <= 1'b0;
            end
          end
          ST_DWELL: begin
            if (timer_q == 16'h0000)
              state_q <= ST_ENGAGED;
            else if (run_s2_q)
              timer_q <= restart_q;
          end
          ST_FAULT: begin
            hold_zero <= 1'b1;
            if (fr_s2_q && !run_s2_q) begin
              brake_fault <= 1'b0;
              state_q <= ST_ENGAGED;
            end
          end
          default: state_q <= ST_ENGAGED;
        endcase
      end
    end
  end

  // torque current ramp; a zero time steps at once
  always @(posedge mclk) begin
    if (!nrst) begin
      ramp_cnt_q <= 16'h0000;
      torque_level <= 16'h0000;
    end else if (!ramp_go_q) begin
      ramp_cnt_q <= 16'h0000;
    end else if (ramp_q == 16'h0000) begin
      torque_level <= ramp_up_q ? RAMP_FULL : 16'h0000;
    end else if (tick_q) begin
      if (ramp_cnt_q >= ramp_q - 16'h0001) begin
        ramp_cnt_q <= 16'h0000;
        if (ramp_up_q && torque_level != RAMP_FULL)
          torque_level <= torque_level + 16'h0001;
        else if (!ramp_up_q && torque_level != 16'h0000)
          torque_level <= torque_level - 16'h0001;
      end else begin
        ramp_cnt_q <= ramp_cnt_q + 16'h0001;
      end
    end
  end

  // registered outputs
  always @(posedge mclk) begin
    if (!nrst) begin
      brake_relay <= 1'b0;
      ref_enable <= 1'b0;
      jump_active <= 1'b0;
    end else begin
      brake_relay <= assigned && (state_q == ST_RELEASE || state_q == ST_RUN || state_q == ST_ENG_DLY);
      ref_enable <= assigned && state_q == ST_RUN && !brake_warn;
      // jump only while reversing and the brake stays released
      jump_active <= assigned && state_q == ST_RUN && rev_s2_q && !ctrl_q[`HBS_CTL_REV_ENG];
    end
  end
endmodule // hbs_sequencer
`default_nettype wire

// [tb/hbs_assertions.sv]
// port-level checker for the hoist brake sequencer
`timescale 1ns/1ps
`default_nettype none
module hbs_assertions (
  input wire mclk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire fault_reset,
  input wire brake_relay,
  input wire ref_enable,
  input wire hold_zero,
  input wire brake_fault,
  input wire brake_warn
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable && pready; endsequence
  a_ready_next: assert property (setup_s |=> access_s) else $error("pready late");
  a_ready_once: assert property (pready |=> !pready) else $error("pready held");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read data");
  a_idle_engaged: assert property ($rose(nrst) |-> !brake_relay && hold_zero && !ref_enable) else $error("not idle");
  a_ref_released: assert property (ref_enable |-> brake_relay) else $error("ref without release");
  a_fault_locks: assert property (brake_fault && !fault_reset && !$past(fault_reset) && !$past(fault_reset, 2)
    |=> brake_fault) else $error("fault dropped");
  a_warn_hold: assert property (brake_warn |-> hold_zero && !brake_relay) else $error("warn without hold");
endmodule // hbs_assertions
bind hbs_sequencer hbs_assertions i_chk (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .fault_reset(fault_reset), .brake_relay(brake_relay),
  .ref_enable(ref_enable), .hold_zero(hold_zero), .brake_fault(brake_fault), .brake_warn(brake_warn));
`default_nettype wire

// [tb/hbs_brake_model.sv]
// brake relay and contact model: contact follows the relay after a travel time
`timescale 1ns/1ps
`default_nettype none
module hbs_brake_model #(
  parameter int TRAVEL = 16
) (
  input wire logic mclk,
  input wire logic brake_relay,
  output logic brake_contact
);
  logic [TRAVEL-1:0] pipe_q = '0;
  // mechanical lag, so the sequencer sees the contact late on both moves
  always @(posedge mclk) begin
    pipe_q <= {pipe_q[TRAVEL-2:0], brake_relay};
  end
  assign brake_contact = pipe_q[TRAVEL-1];
endmodule // hbs_brake_model
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the hoist brake sequencer
`timescale 1ns/1ps
`default_nettype none
`include "hbs_map.vh"
module tb_top;
  logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, run_cmd = 0, zero_speed = 1, fault_reset = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic rd_err;
  logic pready, pslverr, brake_contact, brake_relay, ref_enable, hold_zero, jump_active, brake_fault, brake_warn, irq;
  logic [15:0] torque_level;
  int err_total = 0, tests_run = 0;
  hbs_sequencer i_dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .run_cmd(run_cmd), .reversal_req(1'b0),
    .zero_speed(zero_speed), .brake_contact(brake_contact), .fault_reset(fault_reset), .rated_slip(8'h0c),
    .brake_relay(brake_relay), .ref_enable(ref_enable), .hold_zero(hold_zero), .torque_level(torque_level),
    .jump_active(jump_active), .brake_fault(brake_fault), .brake_warn(brake_warn), .irq(irq));
  hbs_brake_model i_brk (.mclk(mclk), .brake_relay(brake_relay), .brake_contact(brake_contact));
  initial forever #12.5 mclk = ~mclk;
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; waits for pready rather than assuming zero wait states
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    // look half a cycle later: the value settled there is what the next rising edge samples
    @(negedge mclk);
    while (pready !== 1'b1 && n < 50) begin @(negedge mclk); n++; end
    rd = prdata;
    rd_err = pslverr;
    @(posedge mclk);
    if (n >= 50) err_total++;
    psel <= 0; penable <= 0;
  endtask
  function logic pick(input int s);
    case (s) 0: pick = brake_relay; 1: pick = ref_enable; 2: pick = brake_fault; default: pick = brake_warn; endcase
  endfunction
  // bounded poll of one output, then the level is compared
  task wait_for(input int s, input logic v);
    int n;
    for (n = 0; n < 400 && pick(s) !== v; n++) @(negedge mclk);
    chk(pick(s), v);
  endtask
  task cycle(input logic on);
    @(posedge mclk);
    run_cmd <= on; zero_speed <= !on;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    complete_run;
  end
  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1;
    // reset values and a refused address
    apb(0, `HBS_OFF_ENG_TIME, 0); chk(rd, 32'h01f4);
    apb(0, `HBS_OFF_ENG_DLY, 0); chk(rd, 32'h0);
    apb(0, `HBS_OFF_RESTART, 0); chk(rd, 32'h0);
    apb(0, `HBS_OFF_JUMP, 0); chk(rd, 32'h8000);
    apb(0, `HBS_OFF_JUMP_OUT, 0); chk(rd, 32'h0c);
    apb(1, `HBS_OFF_JUMP, 32'hff);
    apb(0, `HBS_OFF_JUMP_OUT, 0); chk(rd, 32'h64);
    apb(0, 12'h0ff, 0); chk(rd, 32'h0);
    chk(rd_err, 1);
    $display("test defaults done");
    // unassigned: run must not release the brake
    cycle(1); repeat (60) @(posedge mclk); chk(brake_relay, 0);
    cycle(0);
    apb(1, `HBS_OFF_IRQ_MASK, 32'h1);
    apb(1, `HBS_OFF_REL_TIME, 32'h0);
    apb(1, `HBS_OFF_ENG_TIME, 32'h0);
    apb(1, `HBS_OFF_CTRL, 32'h0d1);
    // contact gates the reference, zero engage time ends the engage phase with contact still released
    cycle(1); wait_for(0, 1);
    repeat (4) @(posedge mclk); chk(ref_enable, 0);
    wait_for(1, 1);
    chk(torque_level, 16'hffff);
    cycle(0); wait_for(2, 1);
    // irq follows the sticky status one cycle later
    @(negedge mclk);
    chk(brake_relay, 0); chk(irq, 1);
    chk(torque_level, 16'h0);
    @(posedge mclk); fault_reset <= 1;
    wait_for(2, 0);
    @(posedge mclk); fault_reset <= 0;
    apb(1, `HBS_OFF_IRQ_STAT, 32'h1);
    repeat (2) @(negedge mclk);
    chk(irq, 0);
    $display("test fault done");
    // missing response as warning, masked interrupt
    apb(1, `HBS_OFF_CTRL, 32'h0f1);
    repeat (40) @(posedge mclk);
    cycle(1); wait_for(1, 1);
    cycle(0); wait_for(3, 1);
    chk(brake_fault, 0); chk(hold_zero, 1); chk(irq, 0);
    apb(0, `HBS_OFF_IRQ_STAT, 0); chk(rd[1:0], 2'h2);
    apb(1, `HBS_OFF_IRQ_STAT, 32'h2);
    apb(0, `HBS_OFF_IRQ_STAT, 0); chk(rd[1:0], 2'h0);
    $display("test warning done");
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
